// >>> pic_defs.svh
// pic_defs.svh - constants for the prioritized interrupt controller
// assumes: included by pic_pkg.sv and pic_top.sv by bare name
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

`define PIC_NUM_SRC 13
`define PIC_EA_BIT 7
// enable/priority bit positions, reg a
`define PIC_A_EXT_A 0
`define PIC_A_TMR_A 1
`define PIC_A_EXT_B 2
`define PIC_A_TMR_B 3
`define PIC_A_UART 4
`define PIC_A_BROWN 5
`define PIC_A_WDOG 6
// reg b
`define PIC_B_TWI 0
`define PIC_B_KEYPAD 1
`define PIC_B_CMP_B 2
`define PIC_B_ADC 4
`define PIC_B_CMP_A 5
`define PIC_B_BHANG 7
// vector base and spacing
`define PIC_VEC_BASE 16'h0003
`define PIC_VEC_STEP 16'h0008
// power-down wake sources, indexed by source number (vector order)
`define PIC_WAKE_MASK 13'h0FA5
`define PIC_RESET_BYTE 8'h00

`endif

// >>> pic_pkg.sv
// pic_pkg.sv - types for the prioritized interrupt controller
// assumes: pic_defs.svh is on the include path
`include "pic_defs.svh"
package pic_pkg;
  typedef logic [1:0] pic_level_type;
  typedef struct packed {
    logic [7:0] enable_a;
    logic [7:0] enable_b;
    logic [7:0] prio_high_a;
    logic [7:0] prio_low_a;
    logic [7:0] prio_high_b;
    logic [7:0] prio_low_b;
  } pic_cfg_type;
  typedef enum logic [2:0] {
    PIC_IDLE = 3'b001,
    PIC_ACK = 3'b010,
    PIC_HOLD = 3'b100
  } pic_state_type;
endpackage

// >>> pic_top.sv
// pic_top.sv - interrupt arbiter: enables, four levels, ranking, vectors, wake
// assumes: clk is the machine-cycle clock; flags come from on-chip logic on clk,
// external pins are asynchronous and are synchronised here
//
// Behaviour
// - thirteen request sources, each given one of four priority levels
// - per-source enable bit; disabled sources are never vectored
// - global enable bit clear blocks every source at once
// - level formed from high-register bit and low-register bit
// - active routine preempted only by strictly higher pending level
// - routine at highest level is never preempted
// - simultaneous requests of different level: higher level served first
// - equal level ties broken by fixed ranking, pin a first, bus-hang last
// - ranking only breaks ties, never overrides level
// - each source has fixed vector 0003h upward to 0073h
// - uart tx or rx gives one shared request, enable a bit 4
// - two-wire attention flag request, enable b bit 0, rank five
// - only pins, brownout, keypad, comparators, watchdog, adc wake core
// - edge mode: high then low sample sets pin flag, vectoring clears it
// - level mode: pin flag follows sampled low level
`timescale 1ns/1ns
`default_nettype none
`include "pic_defs.svh"

module pic_top
  import pic_pkg::*;
#(
  parameter int NUM_SRC = `PIC_NUM_SRC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire pic_cfg_type cfg,
  input wire logic ext_pin_a_edge_mode,
  input wire logic ext_pin_b_edge_mode,
  // external pins, active low, asynchronous
  input wire logic ext_pin_a_n,
  input wire logic ext_pin_b_n,
  // peripheral flags, same clock
  input wire logic timer_a_overflow_flag,
  input wire logic timer_b_overflow_flag,
  input wire logic uart_tx_done_flag,
  input wire logic uart_rx_done_flag,
  input wire logic brownout_flag,
  input wire logic two_wire_attention_flag,
  input wire logic keypad_flag,
  input wire logic comparator_b_flag,
  input wire logic comparator_a_flag,
  input wire logic watchdog_overflow_flag,
  input wire logic adc_done_flag,
  input wire logic bus_hang_timeout,
  // core handshake
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [3:0] irq_source,
  output logic [1:0] active_level,
  output logic in_service,
  output logic wake_req,
  // pin flags for software view
  output logic ext_pin_a_flag,
  output logic ext_pin_b_flag
);

  localparam int NSRC = NUM_SRC;

  // the ranking, vector and bank tables below are written for thirteen sources
  if (NUM_SRC != 13) begin : g_bad_num_src
    $error("pic_top serves exactly 13 sources");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // rank position (0 = first polled) of each source in vector order
  function automatic logic [3:0] rank_of(input logic [3:0] s);
    case (s)
      4'h0: rank_of = 4'h0;
      4'h1: rank_of = 4'h3;
      4'h2: rank_of = 4'h6;
      4'h3: rank_of = 4'h9;
      4'h4: rank_of = 4'hB;
      4'h5: rank_of = 4'h1;
      4'h6: rank_of = 4'h4;
      4'h7: rank_of = 4'h7;
      4'h8: rank_of = 4'hA;
      4'h9: rank_of = 4'h2;
      4'hA: rank_of = 4'h5;
      4'hB: rank_of = 4'h8;
      default: rank_of = 4'hC;
    endcase
  endfunction

  // slots 004B and 006B are unused: index 9 onward skips one, index 12 two
  function automatic logic [15:0] vector_of(input logic [3:0] s);
    logic [3:0] slot;
    slot = s + {3'h0, s >= 4'h9} + {3'h0, s >= 4'hC};
    vector_of = `PIC_VEC_BASE + 16'({12'h000, slot} << 3);
  endfunction

  // ----------------------------------------------------------------
  // external pin sampling
  // ----------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic pin_a_low;
  logic pin_b_low;
  logic pin_a_prev_low;
  logic pin_b_prev_low;
  logic ack_pin_a;
  logic ack_pin_b;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
    end else begin
      sync_a <= {sync_a[1:0], ext_pin_a_n};
      sync_b <= {sync_b[1:0], ext_pin_b_n};
    end
  end

  // level accepted once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_a_low <= 1'b0;
      pin_b_low <= 1'b0;
      pin_a_prev_low <= 1'b0;
      pin_b_prev_low <= 1'b0;
    end else begin
      if (sync_a[1] == sync_a[2]) pin_a_low <= ~sync_a[2];
      if (sync_b[1] == sync_b[2]) pin_b_low <= ~sync_b[2];
      pin_a_prev_low <= pin_a_low;
      pin_b_prev_low <= pin_b_low;
    end
  end

  // edge flag: new fall wins over the vectoring clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_pin_a_flag <= 1'b0;
    end else if (!ext_pin_a_edge_mode) begin
      ext_pin_a_flag <= pin_a_low;
    end else if (pin_a_low && !pin_a_prev_low) begin
      ext_pin_a_flag <= 1'b1;
    end else if (ack_pin_a) begin
      ext_pin_a_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_pin_b_flag <= 1'b0;
    end else if (!ext_pin_b_edge_mode) begin
      ext_pin_b_flag <= pin_b_low;
    end else if (pin_b_low && !pin_b_prev_low) begin
      ext_pin_b_flag <= 1'b1;
    end else if (ack_pin_b) begin
      ext_pin_b_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // request, enable and level per source (vector order)
  // ----------------------------------------------------------------
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] pend;
  pic_level_type lvl [NSRC];

  assign raw = {bus_hang_timeout, comparator_a_flag, adc_done_flag, watchdog_overflow_flag,
                comparator_b_flag, keypad_flag, two_wire_attention_flag,
                brownout_flag, uart_tx_done_flag | uart_rx_done_flag,
                timer_b_overflow_flag, ext_pin_b_flag, timer_a_overflow_flag, ext_pin_a_flag};
  assign en = {cfg.enable_b[`PIC_B_BHANG], cfg.enable_b[`PIC_B_CMP_A], cfg.enable_b[`PIC_B_ADC],
               cfg.enable_a[`PIC_A_WDOG], cfg.enable_b[`PIC_B_CMP_B], cfg.enable_b[`PIC_B_KEYPAD],
               cfg.enable_b[`PIC_B_TWI], cfg.enable_a[`PIC_A_BROWN], cfg.enable_a[`PIC_A_UART],
               cfg.enable_a[`PIC_A_TMR_B], cfg.enable_a[`PIC_A_EXT_B], cfg.enable_a[`PIC_A_TMR_A],
               cfg.enable_a[`PIC_A_EXT_A]};

  // source i uses bit position from reg a (i<=4, brownout 5, watchdog 6) or reg b
  localparam logic [NSRC*4-1:0] BITPOS = {4'd7, 4'd5, 4'd4, 4'd6, 4'd2, 4'd1, 4'd0,
                                          4'd5, 4'd4, 4'd3, 4'd2, 4'd1, 4'd0};
  localparam logic [NSRC-1:0] IN_B = 13'b1_1101_1100_0000;

  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_src
      localparam int P = int'(BITPOS[i*4 +: 4]);
      assign pend[i] = raw[i] & en[i] & cfg.enable_a[`PIC_EA_BIT];
      assign lvl[i] = IN_B[i] ? {cfg.prio_high_b[P], cfg.prio_low_b[P]}
                              : {cfg.prio_high_a[P], cfg.prio_low_a[P]};
    end
  endgenerate

  // ----------------------------------------------------------------
  // arbitration: level first, then rank
  // ----------------------------------------------------------------
  logic [3:0] win_src;
  logic [1:0] win_lvl;
  logic win_any;

  always_comb begin
    win_src = 4'h0;
    win_lvl = 2'h0;
    win_any = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (pend[i] && (!win_any || lvl[i] > win_lvl ||
          (lvl[i] == win_lvl && rank_of(4'(i)) < rank_of(win_src)))) begin
        win_src = 4'(i);
        win_lvl = lvl[i];
        win_any = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // nesting stack of active levels, one slot per level
  // ----------------------------------------------------------------
  logic [3:0] depth;
  logic [1:0] stack [4];
  logic can_preempt;
  logic take;

  // depth counts active routines; at most one per level can nest
  assign can_preempt = (depth == 4'h0) || (win_lvl > active_level);
  assign irq_req = win_any && can_preempt;
  assign take = irq_req && irq_ack;
  assign ack_pin_a = take && win_src == 4'h0;
  assign ack_pin_b = take && win_src == 4'h2;
  assign in_service = depth != 4'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      depth <= 4'h0;
      active_level <= 2'h0;
      for (int k = 0; k < 4; k++) stack[k] <= 2'h0;
    end else if (take) begin
      stack[depth[1:0]] <= active_level;
      depth <= depth + 4'h1;
      active_level <= win_lvl;
    end else if (irq_return && depth != 4'h0) begin
      depth <= depth - 4'h1;
      active_level <= stack[depth[1:0] - 2'h1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_vector <= 16'h0000;
      irq_source <= 4'h0;
    end else if (win_any) begin
      irq_vector <= vector_of(win_src);
      irq_source <= win_src;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) wake_req <= 1'b0;
    else wake_req <= |(pend & 13'(`PIC_WAKE_MASK));
  end

endmodule // pic_top

`default_nettype wire

// >>> pic_core_model.sv
// pic_core_model.sv - processor side: takes requests, ends routines
// assumes: accept and finish come from the bench on clk
`timescale 1ns/1ns
`default_nettype none
module pic_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic accept,
  input wire logic finish,
  // controller side
  input wire logic irq_req,
  output logic irq_ack,
  output logic irq_return
);
  // ack lags the request a cycle so the vector has settled
  always_ff @(posedge clk) begin
    irq_ack <= !rst && irq_req && accept && !irq_ack;
    irq_return <= !rst && finish && !irq_return;
  end
endmodule // pic_core_model
`default_nettype wire

// >>> pic_top_assertions.sv
// pic_top_assertions.sv - port checker for pic_top
// assumes: bound to pic_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module pic_checker
  import pic_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic rst,
  input wire pic_cfg_type cfg,
  input wire logic ext_pin_a_edge_mode,
  input wire logic ext_pin_b_edge_mode,
  input wire logic ext_pin_a_n,
  input wire logic ext_pin_b_n,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0] irq_source,
  input wire logic [1:0] active_level,
  input wire logic in_service,
  input wire logic ext_pin_a_flag,
  input wire logic ext_pin_b_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // the slot after comparator b is unused
  logic [4:0] slot;
  assign slot = {1'b0, irq_source} + {4'h0, irq_source > 4'h8} + {4'h0, irq_source > 4'hB};
  global_off_a: assert property (
    !cfg.enable_a[7] |-> !irq_req) else $error("request while disabled");
  none_enabled_a: assert property (
    cfg.enable_a[6:0] == 7'h00 && cfg.enable_b == 8'h00 |-> !irq_req) else $error("request unenabled");
  top_level_a: assert property (
    active_level == 2'h3 |-> !irq_req) else $error("top level preempted");
  take_raise_a: assert property (
    irq_req && irq_ack |=> in_service && (!$past(in_service) || active_level > $past(active_level)))
    else $error("bad take");
  idle_level_a: assert property (
    !in_service |-> active_level == 2'h0) else $error("idle level");
  vector_map_a: assert property (
    $changed(irq_vector) |-> irq_vector == 16'h0003 + {8'h00, slot, 3'h0}) else $error("bad vector");
  level_pin_a: assert property (
    !ext_pin_b_edge_mode |-> ext_pin_b_flag == !$past(ext_pin_b_n, 5)) else $error("level flag");
  // a fall must hold two samples to pass the synchroniser filter
  edge_pin_a: assert property (
    ext_pin_a_edge_mode && $past(ext_pin_a_n, 6) && !$past(ext_pin_a_n, 5) && !$past(ext_pin_a_n, 4)
    |-> ext_pin_a_flag)
    else $error("edge flag");
endmodule // pic_checker
`default_nettype wire

// >>> test_prioritized_interrupt_controller.sv
// test_prioritized_interrupt_controller.sv - random and corner checks of pic_top
// assumes: pic_top, pic_core_model and pic_checker compiled first
`timescale 1ns/1ns
`default_nettype none
module test_prioritized_interrupt_controller import pic_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pic_cfg_type cfg = '0;
  logic [12:0] fl = '0;
  logic us = 1'b0;
  logic pa_n = 1'b1;
  logic mode_a = 1'b1;
  logic acc = 1'b0;
  logic fin = 1'b0;
  logic ack, rtn, req, ins, wk, fa, fb;
  logic [15:0] vec;
  logic [3:0] sel;
  logic [1:0] lvl;
  logic [31:0] seed = 32'h9;
  int miscompares = 0;
  int num_checks = 0;
  // per source in vector order: bit position, rank, bank b, wake
  int pos[13] = '{0, 1, 2, 3, 4, 5, 0, 1, 2, 6, 4, 5, 7};
  int rnk[13] = '{1, 4, 7, 10, 12, 2, 5, 8, 11, 3, 6, 9, 13};
  logic [12:0] bank_b = 13'h1DC0;
  logic [12:0] wake = 13'h0FA5;
  always #5 clk = !clk;
  pic_top dut_u (.clk, .rst, .cfg, .ext_pin_a_edge_mode(mode_a), .ext_pin_b_edge_mode(1'b0),
    .ext_pin_a_n(pa_n), .ext_pin_b_n(!fl[2]), .timer_a_overflow_flag(fl[1]), .timer_b_overflow_flag(fl[3]),
    .uart_tx_done_flag(fl[4] & us), .uart_rx_done_flag(fl[4] & !us), .brownout_flag(fl[5]),
    .two_wire_attention_flag(fl[6]), .keypad_flag(fl[7]), .comparator_b_flag(fl[8]),
    .watchdog_overflow_flag(fl[9]), .adc_done_flag(fl[10]), .comparator_a_flag(fl[11]),
    .bus_hang_timeout(fl[12]), .irq_ack(ack), .irq_return(rtn), .irq_req(req), .irq_vector(vec),
    .irq_source(sel), .active_level(lvl), .in_service(ins), .wake_req(wk), .ext_pin_a_flag(fa),
    .ext_pin_b_flag(fb));
  pic_core_model core_u (.clk, .rst, .accept(acc), .finish(fin), .irq_req(req), .irq_ack(ack), .irq_return(rtn));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // {enabled, level} of source i
  function automatic logic [2:0] prop(int i);
    logic [7:0] e, h, l;
    e = bank_b[i] ? cfg.enable_b : cfg.enable_a;
    h = bank_b[i] ? cfg.prio_high_b : cfg.prio_high_a;
    l = bank_b[i] ? cfg.prio_low_b : cfg.prio_low_a;
    return {e[pos[i]] & cfg.enable_a[7], h[pos[i]], l[pos[i]]};
  endfunction
  // above = {busy, running level}; -1 when nothing may request
  function automatic int winner(logic [2:0] above);
    int w;
    logic [2:0] s, b;
    w = -1;
    b = '0;
    for (int i = 0; i < 13; i++) begin
      s = prop(i);
      if (fl[i] && s[2] && (!above[2] || s[1:0] > above[1:0]) &&
          (w < 0 || s[1:0] > b[1:0] || (s[1:0] == b[1:0] && rnk[i] < rnk[w]))) begin
        w = i;
        b = s;
      end
    end
    return w;
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic take();
    int n;
    n = 0;
    @(posedge clk);
    acc <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    acc <= 1'b0;
    if (ack !== 1'b1) begin
      miscompares++;
      complete_run();
    end
    #2;
  endtask
  task automatic ret();
    @(posedge clk);
    fin <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    // the core pulses return here; the level restores at the next edge
    @(posedge clk);
    #2;
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    int w, u;
    logic [2:0] p, p2;
    logic [31:0] r, q;
    logic e;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // short low pulse on edge pin: flag sticks until taken
    repeat (6) @(posedge clk);
    cfg <= {8'h81, 40'h0};
    pa_n <= 1'b0;
    repeat (2) @(posedge clk);
    pa_n <= 1'b1;
    repeat (8) @(posedge clk);
    #2;
    check(fa, 1'b1);
    check(vec, 16'h0003);
    take();
    check(fa, 1'b0);
    ret();
    check(ins, 1'b0);
    $display("edge pin test done");
    // level mode on pin a: flag follows the held low level, then drops
    @(posedge clk);
    mode_a <= 1'b0;
    pa_n <= 1'b0;
    repeat (7) @(posedge clk);
    #2;
    check(fa, 1'b1);
    check(req, 1'b1);
    @(posedge clk);
    pa_n <= 1'b1;
    repeat (7) @(posedge clk);
    #2;
    check(fa, 1'b0);
    @(posedge clk);
    mode_a <= 1'b1;
    $display("level pin test done");
    repeat (60) begin
      @(posedge clk);
      r = rnd();
      q = rnd();
      cfg <= {|r[15:14], r[14:0], q};
      fl <= {r[28:17], 1'b0};
      us <= r[30];
      repeat (7) @(posedge clk);
      #2;
      w = winner(3'b000);
      e = 1'b0;
      for (int i = 0; i < 13; i++) begin
        p = prop(i);
        e |= fl[i] & p[2] & wake[i];
      end
      check(req, w >= 0);
      check(fb, fl[2]);
      check(wk, e);
      if (w >= 0) begin
        p = prop(w);
        check(sel, 16'(w));
        check(vec, 16'h0003 + 16'(8 * (w + (w > 8) + (w > 11))));
        take();
        check(lvl, p[1:0]);
        // fresh requests arrive while the routine runs
        @(posedge clk);
        r = rnd();
        fl <= fl | {r[28:17], 1'b0};
        repeat (7) @(posedge clk);
        #2;
        u = winner({1'b1, p[1:0]});
        check(req, u >= 0);
        if (u >= 0) begin
          p2 = prop(u);
          check(sel, 16'(u));
          take();
          check(lvl, p2[1:0]);
          ret();
          check(lvl, p[1:0]);
        end
        @(posedge clk);
        fl <= '0;
        ret();
        check(ins, 1'b0);
      end
      $display("random case done, winner %0d", w);
    end
    complete_run();
  end
endmodule // test_prioritized_interrupt_controller
bind pic_top pic_checker chk_u (.clk, .rst, .cfg, .ext_pin_a_edge_mode, .ext_pin_b_edge_mode, .ext_pin_a_n,
  .ext_pin_b_n, .irq_ack, .irq_req, .irq_vector, .irq_source, .active_level, .in_service, .ext_pin_a_flag,
  .ext_pin_b_flag);
`default_nettype wire
